// >>> pkg/rtcb_regs.svh
// rtcb_regs.svh: register indices, field positions, reset values, counts
// Byte address of a register is four times its index
`ifndef RTCB_REGS_SVH
`define RTCB_REGS_SVH
// Register indices
`define RTCB_IDX_SEC    6'h00
`define RTCB_IDX_MIN    6'h01
`define RTCB_IDX_HOUR   6'h02
`define RTCB_IDX_WDAY   6'h04
`define RTCB_IDX_DATE   6'h05
`define RTCB_IDX_MONTH  6'h06
`define RTCB_IDX_YEAR   6'h07
`define RTCB_IDX_BANK   6'h08
`define RTCB_IDX_RESTR  6'h0c
`define RTCB_IDX_RSVD   6'h0d
`define RTCB_IDX_STAT   6'h10
`define RTCB_IDX_IEN    6'h11
`define RTCB_IDX_ICLR   6'h12
// bank_select_control fields
`define RTCB_BANK_SEL   0
`define RTCB_ALARM_EN   2
`define RTCB_CLOCK_EN   3
`define RTCB_SECONDS_REQUEST_A     4
`define RTCB_INT_EN     7
`define RTCB_BANK_WMASK 8'h9d
`define RTCB_BANK_RST   8'h00
// counter_reset_control fields
`define RTCB_ALM_RST    4
`define RTCB_CLK_RST    5
`define RTCB_DIS16      6
`define RTCB_DIS1       7
`define RTCB_RESTR_RST  2'h0
// Interrupt events
`define RTCB_EV_16HZ    0
`define RTCB_EV_1HZ     1
`define RTCB_EV_MIN     2
`define RTCB_EV_RSVD    3
`define RTCB_EV_RST     4'h0
// Counting
`define RTCB_DIV_LAST   4'hf
`define RTCB_SEC_HALF   7'h30
`define RTCB_BCD_LAST   7'h59
`define RTCB_WDAY_BAD   3'h7
`endif

// >>> pkg/rtcb_pkg.sv
// rtcb_pkg.sv: types shared by the clock register front end
// Compiled before every design file
`default_nettype none
package rtcb_pkg;
  typedef logic [5:0] rtcb_idx_t;
  typedef logic [7:0] rtcb_byte_t;
  typedef enum logic {
    RTCB_CLOCK_BANK = 1'b0,
    RTCB_ALARM_BANK = 1'b1
  } rtcb_bank_t;
  typedef enum logic [1:0] {
    RTCB_SL_IDLE = 2'b00,
    RTCB_SL_WAIT = 2'b01,
    RTCB_SL_DONE = 2'b10
  } rtcb_sl_state_t;
endpackage : rtcb_pkg
`default_nettype wire

// >>> design/rtcb_ahb_slave.sv
// rtcb_ahb_slave.sv: AHB-Lite slave turning word transfers into byte strobes
// Assumes one master, single transfers, and this hreadyout as the bus hready
`timescale 1ns/10ps
`default_nettype none
module rtcb_ahb_slave
  import rtcb_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  // AHB-Lite
  input  wire logic              hsel_i,
  input  wire logic [ADDR_W-1:0] haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic [31:0]       hwdata_i,
  input  wire logic              hready_i,
  output logic      [31:0]       hrdata_o,
  output logic                   hreadyout_o,
  output logic                   hresp_o,
  // Register side
  output logic                   wr_o,
  output logic                   rd_o,
  output rtcb_idx_t              idx_o,
  output rtcb_byte_t             wdata_o,
  input  wire rtcb_byte_t        rdata_i
);
  rtcb_sl_state_t state;
  rtcb_sl_state_t next_state;
  logic           wr_pend;
  wire logic      take = hsel_i && htrans_i[1] && hready_i;

  // Reads take one wait state so a write just ahead of them has landed
  always_comb begin
    next_state = RTCB_SL_IDLE;
    unique case (state)
      RTCB_SL_WAIT: next_state = RTCB_SL_DONE;
      RTCB_SL_IDLE,
      RTCB_SL_DONE: next_state = (take && !hwrite_i) ? RTCB_SL_WAIT : RTCB_SL_IDLE;
      default:      next_state = RTCB_SL_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state   <= RTCB_SL_IDLE;
      wr_pend <= 1'b0;
      idx_o   <= 6'h00;
    end else begin
      state   <= next_state;
      wr_pend <= take && hwrite_i;
      if (take) idx_o <= haddr_i[7:2];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) hrdata_o <= 32'h0000_0000;
    else if (state == RTCB_SL_WAIT) hrdata_o <= {24'h00_0000, rdata_i};
  end

  assign hreadyout_o = (state != RTCB_SL_WAIT);
  assign hresp_o     = 1'b0;
  assign rd_o        = (state == RTCB_SL_WAIT);
  assign wr_o        = wr_pend;
  assign wdata_o     = hwdata_i[7:0];
endmodule : rtcb_ahb_slave
`default_nettype wire

// >>> design/rtcb_bcd60.sv
// rtcb_bcd60.sv: two-digit BCD counter 00..59 with load
// Assumes load and increment come from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
`include "rtcb_regs.svh"
module rtcb_bcd60 (
  // Clock
  input  wire logic       sys_clk_i,
  // Control
  input  wire logic       load_i,
  input  wire logic [6:0] load_val_i,
  input  wire logic       inc_i,
  // Count
  output logic      [6:0] val_o,
  output logic            wrap_o
);
  logic [6:0] next_val;
  wire logic [6:0] bump = (val_o[3:0] == 4'h9) ? {val_o[6:4] + 3'h1, 4'h0}
                                                : val_o + 7'h01;
  assign wrap_o   = inc_i && !load_i && (val_o == `RTCB_BCD_LAST);
  assign next_val = load_i ? load_val_i : wrap_o ? 7'h00 : inc_i ? bump : val_o;
  // Count survives reset, so no reset term
  always_ff @(posedge sys_clk_i) begin
    val_o <= next_val;
  end
endmodule : rtcb_bcd60
`default_nettype wire

// >>> design/rtcb_top.sv
// rtcb_top.sv: banked register map of a real-time clock with alarm
// Assumes an AHB-Lite master on sys_clk_i and a 16 Hz square wave on tick16_i
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "rtcb_regs.svh"
////////////////////////////////////////////////////////////////////////////////
// Function
// RL1: Two banks, clock and alarm, share one address window
// RL2: Bit 0 of bank_select_control picks the bank seen at shared offsets
// RL3: Decode seconds 0, minutes 1, hours 2, weekday 4..year 7, 8, 0xc
// RL4: Offsets 3, 9 to 0xb, 0xe, 0xf read zero and ignore writes
// RL5: Software never touches offset 0xd
// RL6: Reset clears bank, seconds_request_a, interrupt enable and counter_reset_control fields
// RL7: Time, calendar and alarm fields keep their contents across reset
// RL8: Software loads valid time and calendar before enabling the clock
// RL9: Clock bank fields are BCD weighted at their documented widths
// RL10: Alarm bank: minute, hour, weekday, date, 24/12 bit, two leap bits
// RL11: Clock bank reads return the live count at the read
// RL12: Alarm bank reads return the current register contents
// RL13: Software reads clock registers twice and accepts only matching values
// RL14: Seconds are BCD 00..59 in bits 6..0, bit 7 reads zero
// RL15: Alarm format bit set selects 24-hour, clear 12-hour with PM in bit 5
// RL16: Weekday codes 000..110, code 111 is refused
// RL17: Registers are eight bits, one per word, read-zero bits ignore writes
module rtcb_top
  import rtcb_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  // AHB-Lite slave
  input  wire logic              hsel_i,
  input  wire logic [ADDR_W-1:0] haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic [2:0]        hsize_i,
  input  wire logic [31:0]       hwdata_i,
  input  wire logic              hready_i,
  output logic      [31:0]       hrdata_o,
  output logic                   hreadyout_o,
  output logic                   hresp_o,
  // Time base and interrupt
  input  wire logic              tick16_i,
  output logic                   irq_o
);
  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic       wr_stb;
  logic       rd_stb;
  rtcb_idx_t  idx;
  rtcb_byte_t wdata;
  rtcb_byte_t rdata;
  rtcb_byte_t bank_ctl;
  logic [1:0] restr_dis;
  logic [3:0] div16;
  logic [3:0] irq_stat;
  logic [3:0] irq_en;
  logic [3:0] ev;
  logic [3:0] next_stat;
  logic       tick_s1;
  logic       tick_s2;
  logic       tick_s3;
  logic [6:0] sec;
  logic [6:0] min_c;
  logic [5:0] hour_c;
  logic [2:0] wday_c;
  logic [5:0] date_c;
  logic [4:0] month_c;
  logic [7:0] year_c;
  logic [6:0] min_a;
  logic [5:0] hour_a;
  logic [2:0] wday_a;
  logic [5:0] date_a;
  logic       fmt24;
  logic [1:0] leap;
  logic       sec_wrap;
  logic       min_wrap;
  rtcb_byte_t clk_view [64];
  rtcb_byte_t al_view  [64];

  wire rtcb_bank_t bank = rtcb_bank_t'(bank_ctl[`RTCB_BANK_SEL]);  // RL2

  // Write strobe for a bank-dependent register
  function automatic logic wr_at(input rtcb_idx_t t, input rtcb_bank_t b);
    wr_at = wr_stb && (idx == t) && (bank == b);
  endfunction : wr_at

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave
  rtcb_ahb_slave #(
    .ADDR_W (ADDR_W)
  ) u_slave (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .hsel_i      (hsel_i),
    .haddr_i     (haddr_i),
    .htrans_i    (htrans_i),
    .hwrite_i    (hwrite_i),
    .hwdata_i    (hwdata_i),
    .hready_i    (hready_i),
    .hrdata_o    (hrdata_o),
    .hreadyout_o (hreadyout_o),
    .hresp_o     (hresp_o),
    .wr_o        (wr_stb),
    .rd_o        (rd_stb),
    .idx_o       (idx),
    .wdata_o     (wdata),
    .rdata_i     (rdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Decode
  wire logic wr_bank   = wr_stb && (idx == `RTCB_IDX_BANK);
  wire logic wr_restr  = wr_stb && (idx == `RTCB_IDX_RESTR);
  wire logic wr_ien    = wr_stb && (idx == `RTCB_IDX_IEN);
  wire logic wr_iclr   = wr_stb && (idx == `RTCB_IDX_ICLR);
  wire logic rsvd_hit  = (wr_stb || rd_stb) && (idx == `RTCB_IDX_RSVD);
  wire logic clk_rst   = wr_restr && wdata[`RTCB_CLK_RST];
  wire logic alm_rst   = wr_restr && wdata[`RTCB_ALM_RST];
  wire logic run       = bank_ctl[`RTCB_CLOCK_EN];
  wire logic adj_go    = bank_ctl[`RTCB_SECONDS_REQUEST_A];
  wire logic adj_carry = adj_go && (sec >= `RTCB_SEC_HALF);
  wire logic tick_rise = tick_s2 && !tick_s3;
  wire logic second    = tick_rise && (div16 == `RTCB_DIV_LAST);
  wire logic wday_ok   = (wdata[2:0] != `RTCB_WDAY_BAD);
  // Spelled out: a port connection only wakes on a function's arguments, not on what it reads
  wire logic ld_sec    = wr_stb && (idx == `RTCB_IDX_SEC) && (bank == RTCB_CLOCK_BANK);
  wire logic ld_min    = wr_stb && (idx == `RTCB_IDX_MIN) && (bank == RTCB_CLOCK_BANK);

  ////////////////////////////////////////////////////////////////////////////////
  // Time base: tick16_i is a pin, tick_s1 only feeds tick_s2
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tick_s1 <= 1'b0;
      tick_s2 <= 1'b0;
      tick_s3 <= 1'b0;
    end else begin
      tick_s1 <= tick16_i;
      tick_s2 <= tick_s1;
      tick_s3 <= tick_s2;
    end
  end

  // Clock reset restarts the sub-second phase, not the count
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || clk_rst) begin
      div16 <= 4'h0;
    end else if (tick_rise) begin
      div16 <= div16 + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      bank_ctl <= `RTCB_BANK_RST;  // RL6
    end else if (wr_bank) begin
      bank_ctl <= wdata & `RTCB_BANK_WMASK;  // RL17
    end else if (adj_go) begin
      bank_ctl[`RTCB_SECONDS_REQUEST_A] <= 1'b0;
    end
  end

  // Reset bits are strobes and read back as zero
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      restr_dis <= `RTCB_RESTR_RST;  // RL6
    end else if (wr_restr) begin
      restr_dis <= wdata[`RTCB_DIS1:`RTCB_DIS16];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clock bank: seconds and minutes count, seconds_request_a rounds to the nearest minute
  rtcb_bcd60 u_sec (
    .sys_clk_i  (sys_clk_i),
    .load_i     (ld_sec || adj_go),
    .load_val_i (adj_go ? 7'h00 : wdata[6:0]),  // RL14
    .inc_i      (second && run),
    .val_o      (sec),
    .wrap_o     (sec_wrap)
  );

  rtcb_bcd60 u_min (
    .sys_clk_i  (sys_clk_i),
    .load_i     (ld_min),
    .load_val_i (wdata[6:0]),  // RL9
    .inc_i      (sec_wrap || adj_carry),
    .val_o      (min_c),
    .wrap_o     (min_wrap)
  );

  // No reset term: contents persist across reset
  always_ff @(posedge sys_clk_i) begin  // RL7
    if (wr_at(`RTCB_IDX_HOUR, RTCB_CLOCK_BANK)) hour_c <= wdata[5:0];  // RL9
    if (wr_at(`RTCB_IDX_WDAY, RTCB_CLOCK_BANK) && wday_ok) wday_c <= wdata[2:0];  // RL16
    if (wr_at(`RTCB_IDX_DATE, RTCB_CLOCK_BANK)) date_c <= wdata[5:0];  // RL9
    if (wr_at(`RTCB_IDX_MONTH, RTCB_CLOCK_BANK)) month_c <= wdata[4:0];  // RL9
    if (wr_at(`RTCB_IDX_YEAR, RTCB_CLOCK_BANK)) year_c <= wdata;  // RL9
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Alarm bank; alarm reset clears the compare fields only
  always_ff @(posedge sys_clk_i) begin
    if (alm_rst) begin
      min_a  <= 7'h00;
      hour_a <= 6'h00;
      wday_a <= 3'h0;
      date_a <= 6'h00;
    end else begin
      if (wr_at(`RTCB_IDX_MIN, RTCB_ALARM_BANK)) min_a <= wdata[6:0];  // RL10
      if (wr_at(`RTCB_IDX_HOUR, RTCB_ALARM_BANK)) hour_a <= wdata[5:0];  // RL10
      if (wr_at(`RTCB_IDX_WDAY, RTCB_ALARM_BANK) && wday_ok) wday_a <= wdata[2:0];  // RL16
      if (wr_at(`RTCB_IDX_DATE, RTCB_ALARM_BANK)) date_a <= wdata[5:0];  // RL10
    end
  end

  // 24/12 select and leap phase survive reset too
  always_ff @(posedge sys_clk_i) begin
    if (wr_at(`RTCB_IDX_MONTH, RTCB_ALARM_BANK)) fmt24 <= wdata[0];  // RL15
    if (wr_at(`RTCB_IDX_YEAR, RTCB_ALARM_BANK)) leap <= wdata[1:0];  // RL10
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read views: anything not filled in reads zero, so gaps and 0xd do too
  always_comb begin
    clk_view = '{default: 8'h00};  // RL4
    al_view  = '{default: 8'h00};
    clk_view[`RTCB_IDX_SEC]   = {1'b0, sec};  // RL11
    clk_view[`RTCB_IDX_MIN]   = {1'b0, min_c};  // RL11
    clk_view[`RTCB_IDX_HOUR]  = {2'b00, hour_c};
    clk_view[`RTCB_IDX_WDAY]  = {5'h00, wday_c};
    clk_view[`RTCB_IDX_DATE]  = {2'b00, date_c};
    clk_view[`RTCB_IDX_MONTH] = {3'h0, month_c};
    clk_view[`RTCB_IDX_YEAR]  = year_c;
    al_view[`RTCB_IDX_MIN]    = {1'b0, min_a};  // RL12
    al_view[`RTCB_IDX_HOUR]   = {2'b00, hour_a};
    al_view[`RTCB_IDX_WDAY]   = {5'h00, wday_a};
    al_view[`RTCB_IDX_DATE]   = {2'b00, date_a};
    al_view[`RTCB_IDX_MONTH]  = {7'h00, fmt24};
    al_view[`RTCB_IDX_YEAR]   = {6'h00, leap};
    clk_view[`RTCB_IDX_BANK]  = bank_ctl;  // RL1
    al_view[`RTCB_IDX_BANK]   = bank_ctl;
    clk_view[`RTCB_IDX_RESTR] = {restr_dis, 6'h00};
    al_view[`RTCB_IDX_RESTR]  = {restr_dis, 6'h00};
    clk_view[`RTCB_IDX_STAT]  = {4'h0, irq_stat};
    al_view[`RTCB_IDX_STAT]   = {4'h0, irq_stat};
    clk_view[`RTCB_IDX_IEN]   = {4'h0, irq_en};
    al_view[`RTCB_IDX_IEN]    = {4'h0, irq_en};
  end

  assign rdata = (bank == RTCB_ALARM_BANK) ? al_view[idx] : clk_view[idx];  // RL3

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupts: a new event beats a clear in the same cycle
  assign ev[`RTCB_EV_16HZ] = tick_rise && !restr_dis[0];
  assign ev[`RTCB_EV_1HZ]  = second && !restr_dis[1];
  assign ev[`RTCB_EV_MIN]  = min_wrap;
  assign ev[`RTCB_EV_RSVD] = rsvd_hit;  // RL5
  assign next_stat = (irq_stat & ~(wr_iclr ? wdata[3:0] : 4'h0)) | ev;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_stat <= `RTCB_EV_RST;
      irq_en   <= `RTCB_EV_RST;
    end else begin
      irq_stat <= next_stat;
      if (wr_ien) irq_en <= wdata[3:0];
    end
  end

  assign irq_o = bank_ctl[`RTCB_INT_EN] && |(irq_stat & irq_en);

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  property p_unused_zero;
    rd_stb && (idx inside {6'h03, 6'h09, 6'h0a, 6'h0b, 6'h0e, 6'h0f}) |=> hrdata_o == 32'h0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused offset read nonzero"); // RL4

  property p_reset_fields;
    $fell(rst_i) |-> bank_ctl == `RTCB_BANK_RST && restr_dis == `RTCB_RESTR_RST;
  endproperty
  a_reset_fields: assert property (p_reset_fields) else $error("control not cleared"); // RL6

  property p_alarm_no_sec;
    rd_stb && idx == `RTCB_IDX_SEC && bank == RTCB_ALARM_BANK |=> hrdata_o == 32'h0;
  endproperty
  a_alarm_no_sec: assert property (p_alarm_no_sec) else $error("alarm seconds nonzero"); // RL2

  property p_sec_live;
    rd_stb && idx == `RTCB_IDX_SEC && bank == RTCB_CLOCK_BANK
      |=> hrdata_o == {25'h0, $past(sec)};
  endproperty
  a_sec_live: assert property (p_sec_live) else $error("seconds read not live"); // RL11

  property p_wday_guard;
    wr_stb && idx == `RTCB_IDX_WDAY && wdata[2:0] == `RTCB_WDAY_BAD
      |=> $stable(wday_c) && $stable(wday_a);
  endproperty
  a_wday_guard: assert property (p_wday_guard) else $error("weekday 111 stored"); // RL16

  property p_leap_read;
    rd_stb && idx == `RTCB_IDX_YEAR && bank == RTCB_ALARM_BANK
      |=> hrdata_o == {30'h0, $past(leap)};
  endproperty
  a_leap_read: assert property (p_leap_read) else $error("leap phase read wrong"); // RL10

  property p_fmt_read;
    rd_stb && idx == `RTCB_IDX_MONTH && bank == RTCB_ALARM_BANK
      |=> hrdata_o == {31'h0, $past(fmt24)};
  endproperty
  a_fmt_read: assert property (p_fmt_read) else $error("format bit read wrong"); // RL15

  property p_read_wait;
    rd_stb |-> !hreadyout_o ##1 hreadyout_o;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state wrong"); // RL17

  property p_rsvd_flag;
    rsvd_hit |=> irq_stat[`RTCB_EV_RSVD];
  endproperty
  a_rsvd_flag: assert property (p_rsvd_flag) else $error("reserved access not flagged"); // RL5

  property p_bank_read;
    rd_stb && idx == `RTCB_IDX_BANK |=> hrdata_o[7:0] == $past(bank_ctl);
  endproperty
  a_bank_read: assert property (p_bank_read) else $error("bank register read wrong"); // RL1

  property p_set_wins;
    wr_iclr && |ev |=> (irq_stat & $past(ev)) == $past(ev);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to clear");
endmodule : rtcb_top
`default_nettype wire

// >>> test/test_rtcb_top.sv
// test_rtcb_top.sv: self-checking bench for the banked clock register map
// Bench is the only AHB-Lite master; hready is the slave's own hreadyout
`timescale 1ns/10ps
`default_nettype none
`include "rtcb_regs.svh"
module test_rtcb_top
  import rtcb_pkg::*;
;
  logic        sys_clk_i   = 1'b0;
  logic        rst_i       = 1'b1;
  logic        hsel        = 1'b0;
  logic [7:0]  haddr       = 8'h00;
  logic [1:0]  htrans      = 2'h0;
  logic        hwrite      = 1'b0;
  logic [31:0] hwdata      = 32'h0;
  logic        tick        = 1'b0;
  wire  [31:0] hrdata;
  wire         hready;
  wire         hresp;
  wire         irq;
  int          miscompares = 0;
  int          checked     = 0;
  int          cycles      = 0;
  logic [31:0] seed        = 32'h4d707ea7;
  logic [7:0]  exp_v [0:1][0:7];
  localparam logic [7:0] CLK_MASK [0:7] = '{8'h7f, 8'h7f, 8'h3f, 8'h00,
                                            8'h07, 8'h3f, 8'h1f, 8'hff};
  localparam logic [7:0] ALM_MASK [0:7] = '{8'h00, 8'h7f, 8'h3f, 8'h00,
                                            8'h07, 8'h3f, 8'h01, 8'h03};

  rtcb_top i_dut (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .hsel_i      (hsel),
    .haddr_i     (haddr),
    .htrans_i    (htrans),
    .hwrite_i    (hwrite),
    .hsize_i     (3'h2),
    .hwdata_i    (hwdata),
    .hready_i    (hready),
    .hrdata_o    (hrdata),
    .hreadyout_o (hready),
    .hresp_o     (hresp),
    .tick16_i    (tick),
    .irq_o       (irq)
  );

  always #20 sys_clk_i = ~sys_clk_i;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction : lfsr

  // Only legal BCD values: out-of-range time is forbidden to software
  function automatic logic [7:0] rnd_bcd(input int lo, input int hi);
    int n;
    seed = lfsr(seed);
    n = lo + int'(seed[15:0]) % (hi - lo + 1);
    return {4'(n / 10), 4'(n % 10)};
  endfunction : rnd_bcd

  function automatic logic [7:0] pick(input int i);
    case (i)
      0, 1:    return rnd_bcd(0, 59);
      2:       return rnd_bcd(0, 23);
      4:       return rnd_bcd(0, 6);
      5:       return rnd_bcd(1, 31);
      6:       return rnd_bcd(1, 12);
      default: return rnd_bcd(0, 99);
    endcase
  endfunction : pick

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    checked++;
    if (got !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, e);
    end
  endtask : chk

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  // Look at hready mid-cycle, act right after the following rising edge
  task automatic wait_rdy(output logic [31:0] d);
    logic ok;
    ok = 1'b0;
    while (!ok) begin
      @(negedge sys_clk_i);
      ok = (hready === 1'b1);
      d = hrdata;
      @(posedge sys_clk_i);
    end
  endtask : wait_rdy

  task automatic bus(input logic w, input rtcb_idx_t idx, input logic [7:0] wd,
                     output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy(q);
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    wait_rdy(q);
  endtask : bus

  task automatic wr(input rtcb_idx_t idx, input logic [7:0] v);
    logic [31:0] q;
    bus(1'b1, idx, v, q);
  endtask : wr

  task automatic rd_chk(input rtcb_idx_t idx, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk(q, {24'h0, e});
    chk({31'h0, hresp}, 32'h0);
  endtask : rd_chk

  // Reads a live count twice; the two reads must match each other and the expected value
  task automatic rd_twice(input rtcb_idx_t idx, input logic [7:0] e);
    logic [31:0] a;
    logic [31:0] b;
    bus(1'b0, idx, 8'h00, a);
    bus(1'b0, idx, 8'h00, b);
    chk(b, a);
    chk(a, {24'h0, e});
  endtask : rd_twice

  task automatic chk_irq(input logic e);
    @(negedge sys_clk_i);
    chk({31'h0, irq}, {31'h0, e});
    @(posedge sys_clk_i);
  endtask : chk_irq

  task automatic pulse(input int n);
    repeat (n) begin
      tick <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      tick <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
    end
  endtask : pulse

  task automatic fill(input bit alm);
    logic [7:0] v;
    logic [7:0] m;
    for (int i = int'(alm); i < 8; i++) begin
      v = pick(i);
      m = alm ? ALM_MASK[i] : CLK_MASK[i];
      wr(6'(i), v | ~m);
      exp_v[alm][i] = v & m;
    end
  endtask : fill

  task automatic verify(input bit alm);
    for (int i = int'(alm); i < 8; i++) rd_chk(6'(i), exp_v[alm][i]);
  endtask : verify

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      summarize();
    end
  end

  initial begin
    do_reset();
    rd_chk(`RTCB_IDX_BANK, 8'h00);
    rd_chk(`RTCB_IDX_RESTR, 8'h00);
    $display("test reset values done");
    for (int r = 0; r < 3; r++) begin
      wr(`RTCB_IDX_BANK, 8'h00);
      fill(1'b0);
      verify(1'b0);
      wr(`RTCB_IDX_BANK, {7'h0, RTCB_ALARM_BANK});
      fill(1'b1);
      verify(1'b1);
      wr(`RTCB_IDX_WDAY, 8'h07);
      rd_chk(`RTCB_IDX_WDAY, exp_v[1][4]);
      wr(`RTCB_IDX_BANK, 8'h00);
      verify(1'b0);
    end
    $display("test banks done");
    foreach (CLK_MASK[i]) begin
      wr(6'h09 + 6'(i % 3), 8'hff);
      rd_chk(6'h09 + 6'(i % 3), 8'h00);
    end
    wr(6'h0e, 8'hff);
    wr(6'h0f, 8'hff);
    rd_chk(6'h0e, 8'h00);
    rd_chk(6'h0f, 8'h00);
    rd_chk(6'h20, 8'h00);
    wr(`RTCB_IDX_BANK, 8'he2);
    rd_chk(`RTCB_IDX_BANK, 8'h80);
    wr(`RTCB_IDX_RESTR, 8'hcf);
    rd_chk(`RTCB_IDX_RESTR, 8'hc0);
    $display("test unused places done");
    wr(`RTCB_IDX_RESTR, 8'h00);
    wr(`RTCB_IDX_IEN, 8'h01);
    wr(`RTCB_IDX_BANK, 8'h80);
    pulse(1);
    rd_chk(`RTCB_IDX_STAT, 8'h01);
    chk_irq(1'b1);
    wr(`RTCB_IDX_IEN, 8'h00);
    chk_irq(1'b0);
    wr(`RTCB_IDX_IEN, 8'h01);
    chk_irq(1'b1);
    wr(`RTCB_IDX_BANK, 8'h00);
    chk_irq(1'b0);
    wr(`RTCB_IDX_BANK, 8'h80);
    wr(`RTCB_IDX_ICLR, 8'h01);
    rd_chk(`RTCB_IDX_STAT, 8'h00);
    chk_irq(1'b0);
    wr(`RTCB_IDX_RESTR, 8'h40);
    pulse(1);
    rd_chk(`RTCB_IDX_STAT, 8'h00);
    $display("test interrupt done");
    // Divider restarted by clock reset, so the sixteenth tick ends the second
    wr(`RTCB_IDX_SEC, 8'h59);
    wr(`RTCB_IDX_MIN, 8'h10);
    wr(`RTCB_IDX_RESTR, 8'h20);
    wr(`RTCB_IDX_BANK, 8'h08);
    pulse(15);
    rd_twice(`RTCB_IDX_SEC, 8'h59);
    pulse(1);
    rd_twice(`RTCB_IDX_SEC, 8'h00);
    rd_twice(`RTCB_IDX_MIN, 8'h11);
    rd_chk(`RTCB_IDX_STAT, 8'h03);
    wr(`RTCB_IDX_BANK, 8'h00);
    exp_v[0][0] = 8'h00;
    exp_v[0][1] = 8'h11;
    $display("test live count done");
    wr(`RTCB_IDX_BANK, 8'h91);
    wr(`RTCB_IDX_RESTR, 8'hc0);
    do_reset();
    rd_chk(`RTCB_IDX_BANK, 8'h00);
    rd_chk(`RTCB_IDX_RESTR, 8'h00);
    verify(1'b0);
    $display("test reset keeps time done");
    summarize();
  end
endmodule : test_rtcb_top
`default_nettype wire
